// file: shared/qesc_pkg.sv
/*
 Shared constants and types for the quadrature encoder status/compare block.
 Assumes a 16-bit register port with one-cycle strobes and registered read data.
*/
package qesc_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 5;
  localparam int NUM_EVT = 7;

  // Register indices
  localparam logic [4:0] ADDR_STATUS = 5'h00;
  localparam logic [4:0] ADDR_GE_HI = 5'h01;
  localparam logic [4:0] ADDR_GE_LO = 5'h02;
  localparam logic [4:0] ADDR_LE_HI = 5'h03;
  localparam logic [4:0] ADDR_LE_LO = 5'h04;
  localparam logic [4:0] ADDR_INIT_HI = 5'h05;
  localparam logic [4:0] ADDR_INIT_LO = 5'h06;
  localparam logic [4:0] ADDR_CTRL = 5'h07;
  localparam logic [4:0] ADDR_POS_HI = 5'h08;
  localparam logic [4:0] ADDR_POS_LO = 5'h09;
  localparam logic [4:0] ADDR_IDX_HI = 5'h0a;
  localparam logic [4:0] ADDR_IDX_LO = 5'h0b;
  localparam logic [4:0] ADDR_INTV_HI = 5'h0c;
  localparam logic [4:0] ADDR_INTV_LO = 5'h0d;
  localparam logic [4:0] ADDR_VEL = 5'h0e;
  localparam logic [4:0] ADDR_CLEAR = 5'h0f;
  localparam logic [4:0] ADDR_ENABLE = 5'h10;

  // Event index order; flag of event i at bit 2i+1, enable at bit 2i
  localparam int EVT_INDEX = 0;
  localparam int EVT_HOME = 1;
  localparam int EVT_VEL_OV = 2;
  localparam int EVT_HOMING = 3;
  localparam int EVT_POS_OV = 4;
  localparam int EVT_LE = 5;
  localparam int EVT_GE = 6;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_INDEX_HANDLING_MODE_LSB = 4;
  localparam int CTRL_EN_BIT = 15;

  localparam logic [2:0] MODE_QUAD_X4 = 3'h0;
  localparam logic [2:0] MODE_EXT_UPDN = 3'h1;
  localparam logic [2:0] MODE_GATED_CNT = 3'h2;
  localparam logic [2:0] MODE_GATED_TMR = 3'h3;
  localparam logic [2:0] MODE_INT_TMR = 3'h4;

  localparam logic [2:0] INDEX_HANDLING_MODE_HOME_IDX = 3'h3;
  localparam logic [2:0] INDEX_HANDLING_MODE_HOME_SIG = 3'h4;

  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] VEL_MAX = 16'h7fff;
  localparam logic [15:0] VEL_MIN = 16'h8000;
  localparam logic [31:0] POS_MAX = 32'hffff_ffff;

  typedef struct packed {
    logic a;
    logic b;
    logic index;
    logic home;
    logic dir;
    logic gate;
  } qesc_pins_s;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } qesc_bus_s;
endpackage : qesc_pkg

// file: sim/qesc_enc_model.sv
/*
 Incremental shaft encoder driving two quadrature phases.
 Assumes the bench calls move from one thread; gap sets prompt or slow steps.
*/
`timescale 1ns/1ps
module qesc_enc_model (
  input wire logic clk_i,
  output logic a_o,
  output logic b_o
);
  logic [1:0] ph_q = 2'h0;

  // Gray order 00,10,11,01 so only one phase moves per step
  assign a_o = ph_q[1] ^ ph_q[0];
  assign b_o = ph_q[1];

  task automatic move(input logic up, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      repeat (gap) @(posedge clk_i);
      ph_q <= up ? ph_q + 2'h1 : ph_q - 2'h1;
    end
    repeat (gap) @(posedge clk_i);
  endtask : move
endmodule : qesc_enc_model

// file: sim/qesc_properties.sv
/*
 Checker for the register port and interrupt of qesc_top.
 Assumes one register master and strobes that never coincide.
*/
`timescale 1ns/1ps
module qesc_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic irq_o
);
  logic [15:0] ge_hi_q;
  logic [15:0] ge_lo_q;
  logic [15:0] en_q;

  // Shadow of what software wrote, enables kept at their status bit positions
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ge_hi_q <= 16'h0000;
      ge_lo_q <= 16'h0000;
      en_q <= 16'h0000;
    end else if (wr_i) begin
      if (addr_i == qesc_pkg::ADDR_GE_HI) ge_hi_q <= wdata_i;
      if (addr_i == qesc_pkg::ADDR_GE_LO) ge_lo_q <= wdata_i;
      if (addr_i == qesc_pkg::ADDR_STATUS) en_q <= wdata_i & 16'h1555;
      if (addr_i == qesc_pkg::ADDR_ENABLE) for (int i = 0; i < 7; i++) en_q[2*i] <= wdata_i[i];
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside read cycle");
  a_ge_upper_read: assert property (rd_i && addr_i == qesc_pkg::ADDR_GE_HI |=> rdata_o == ge_hi_q)
    else $error("upper threshold half read wrong");
  a_ge_lower_read: assert property (rd_i && addr_i == qesc_pkg::ADDR_GE_LO |=> rdata_o == ge_lo_q)
    else $error("lower threshold half read wrong");
  a_enable_bits_read: assert property (rd_i && addr_i == qesc_pkg::ADDR_STATUS |=> (rdata_o & 16'h1555) == en_q)
    else $error("status enable bits read wrong");
  a_status_top_zero: assert property (rd_i && addr_i == qesc_pkg::ADDR_STATUS |=> rdata_o[15:14] == 2'b00)
    else $error("status top bits not zero");
  a_clear_reads_zero: assert property (rd_i && addr_i == qesc_pkg::ADDR_CLEAR |=> rdata_o == 16'h0000)
    else $error("clear register read not zero");
  a_unmapped_zero: assert property (rd_i && addr_i > qesc_pkg::ADDR_ENABLE |=> rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_irq_needs_enable: assert property (irq_o |-> en_q != 16'h0000)
    else $error("interrupt with no enable set");
  a_irq_from_flag: assert property ((rd_i && addr_i == qesc_pkg::ADDR_STATUS) ##1
    ((rdata_o & (rdata_o >> 1) & 16'h1555) != 16'h0000) |-> irq_o)
    else $error("enabled flag set but no interrupt");

  cover property ($rose(irq_o));
  cover property (wr_i && addr_i == qesc_pkg::ADDR_CLEAR);
  cover property (rd_i && addr_i == qesc_pkg::ADDR_STATUS ##1 rdata_o[9]);
endmodule : qesc_properties

bind qesc_top qesc_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));

// file: sim/tb_quadrature_encoder_status_compare.sv
/*
 Self-checking bench for qesc_top: thresholds, sticky flags, interrupt, overflow.
 Assumes the encoder model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module tb_quadrature_encoder_status_compare;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] addr_i = 5'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic index_i = 1'b0;
  logic home_i = 1'b0;
  logic dir_i = 1'b0;
  logic gate_i = 1'b0;
  logic [15:0] rdata_o;
  logic [15:0] d;
  logic irq_o;
  logic enc_a;
  logic enc_b;
  int fails = 0;
  int checks = 0;

  qesc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .enc_a_i(enc_a), .enc_b_i(enc_b), .index_i(index_i), .home_i(home_i),
    .dir_i(dir_i), .gate_i(gate_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o));
  qesc_enc_model enc (.clk_i(clk_i), .a_o(enc_a), .b_o(enc_b));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  // Read data stands only in the cycle after the strobe
  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    check($sformatf("reg %h", a), d, exp);
  endtask : rchk

  // One-cycle pulse on index (sel 0) or home (sel 1)
  task automatic pulse(input logic sel);
    @(posedge clk_i);
    if (sel) begin
      home_i <= 1'b1;
    end else begin
      index_i <= 1'b1;
    end
    @(posedge clk_i);
    index_i <= 1'b0;
    home_i <= 1'b0;
  endtask : pulse

  task automatic ichk(input logic exp);
    #1 check("irq", {15'h0000, irq_o}, {15'h0000, exp});
  endtask : ichk

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (4000) @(posedge clk_i);
    fails++;
    complete_run;
  end

  initial begin
    @(negedge rst_i);
    rchk(qesc_pkg::ADDR_GE_HI, 16'h0000);
    rchk(qesc_pkg::ADDR_GE_LO, 16'h0000);
    rchk(qesc_pkg::ADDR_STATUS, 16'h2800);
    ichk(1'b0);
    $display("test reset done");
    wr(qesc_pkg::ADDR_GE_HI, 16'ha5c3);
    rchk(qesc_pkg::ADDR_GE_HI, 16'ha5c3);
    wr(qesc_pkg::ADDR_GE_HI, 16'h0000);
    wr(qesc_pkg::ADDR_GE_LO, 16'h0008);
    rchk(qesc_pkg::ADDR_GE_LO, 16'h0008);
    wr(qesc_pkg::ADDR_STATUS, 16'h1000);
    rchk(qesc_pkg::ADDR_STATUS, 16'h1800);
    ichk(1'b0);
    $display("test threshold done");
    wr(qesc_pkg::ADDR_CTRL, 16'h8000);
    enc.move(1'b1, 7, 2);
    rchk(qesc_pkg::ADDR_STATUS, 16'h1800);
    enc.move(1'b1, 1, 6);
    rchk(qesc_pkg::ADDR_POS_LO, 16'h0008);
    ichk(1'b1);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3800);
    wr(qesc_pkg::ADDR_CLEAR, 16'h2800);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3000);
    wr(qesc_pkg::ADDR_STATUS, 16'h0000);
    rchk(qesc_pkg::ADDR_STATUS, 16'h2000);
    ichk(1'b0);
    wr(qesc_pkg::ADDR_ENABLE, 16'h0040);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3000);
    ichk(1'b1);
    $display("test compare done");
    wr(qesc_pkg::ADDR_POS_LO, 16'h1234);
    rchk(qesc_pkg::ADDR_POS_LO, 16'h0008);
    rchk(5'h1f, 16'h0000);
    rchk(qesc_pkg::ADDR_CLEAR, 16'h0000);
    enc.move(1'b0, 9, 2);
    rchk(qesc_pkg::ADDR_POS_HI, 16'hffff);
    rchk(qesc_pkg::ADDR_POS_LO, 16'hffff);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3a00);
    $display("test overflow done");
    wr(qesc_pkg::ADDR_INIT_LO, 16'h0010);
    rchk(qesc_pkg::ADDR_INIT_LO, 16'h0010);
    wr(qesc_pkg::ADDR_CTRL, 16'h8030);
    pulse(1'b0);
    rchk(qesc_pkg::ADDR_POS_LO, 16'h0010);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3a82);
    enc.move(1'b1, 2, 2);
    // Second index edge must not reinitialize again
    pulse(1'b0);
    rchk(qesc_pkg::ADDR_POS_LO, 16'h0012);
    wr(qesc_pkg::ADDR_CTRL, 16'h8041);
    pulse(1'b1);
    enc.move(1'b1, 4, 2);
    rchk(qesc_pkg::ADDR_POS_LO, 16'h000f);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3a8a);
    $display("test homing done");
    wr(qesc_pkg::ADDR_CTRL, 16'h8002);
    dir_i <= 1'b1;
    enc.move(1'b1, 4, 2);
    gate_i <= 1'b1;
    enc.move(1'b1, 4, 2);
    rchk(qesc_pkg::ADDR_POS_LO, 16'h0010);
    rchk(qesc_pkg::ADDR_VEL, 16'h0001);
    rchk(qesc_pkg::ADDR_VEL, 16'h0000);
    wr(qesc_pkg::ADDR_CLEAR, 16'h0a8a);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3000);
    wr(qesc_pkg::ADDR_LE_LO, 16'h0020);
    wr(qesc_pkg::ADDR_ENABLE, 16'h0060);
    rchk(qesc_pkg::ADDR_STATUS, 16'h3c00);
    rchk(qesc_pkg::ADDR_ENABLE, 16'h0060);
    ichk(1'b1);
    $display("test modes done");
    complete_run;
  end
endmodule : tb_quadrature_encoder_status_compare

// file: verilog/qesc_top.sv
/*
 Quadrature encoder position, index, interval and velocity counters with
 greater-or-equal / less-or-equal compare, sticky event flags and one level
 interrupt. Assumes encoder pins already synchronous to clk_i and a single
 register master on the plain strobe port.
*/
`timescale 1ns/1ps

// Function
// - Keep 32-bit position, index and interval counters plus 16-bit velocity counter.
// - Support x4 quadrature, external up/down, gated count, gated timer, internal timer.
// - Provide 32-bit low compare threshold and 32-bit init value loaded into position on homing reinitialization.
// - Greater-or-equal threshold from upper and lower 16-bit halves, both reset zero.
// - Flag bit 9 on position overflow, bit 5 on velocity overflow.
// - Homing flag set on position reinitialization, only in index modes 011 or 100.
// - Each flag paired with read/write enable bit directly below it.
module qesc_top #(
  parameter int PRESCALE = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  input wire logic index_i,
  input wire logic home_i,
  input wire logic dir_i,
  input wire logic gate_i,
  input wire logic [4:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic irq_o
);
  generate
    if (PRESCALE < 1 || PRESCALE > 65535) begin : g_bad_prescale
      $error("PRESCALE must be 1..65535");
    end
  endgenerate

  qesc_pkg::qesc_pins_s pins;
  qesc_pkg::qesc_pins_s pins_q;
  qesc_pkg::qesc_bus_s bus;

  assign pins = '{a: enc_a_i, b: enc_b_i, index: index_i, home: home_i, dir: dir_i, gate: gate_i};
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  logic [15:0] ge_hi_q;
  logic [15:0] ge_lo_q;
  logic [15:0] le_hi_q;
  logic [15:0] le_lo_q;
  logic [15:0] init_hi_q;
  logic [15:0] init_lo_q;
  logic [15:0] ctrl_q;
  logic [31:0] pos_q;
  logic [31:0] pos_d;
  logic [31:0] idx_cnt_q;
  logic [31:0] intv_q;
  logic [31:0] intv_hold_q;
  logic [15:0] vel_q;
  logic [6:0] flag_q;
  logic [6:0] en_q;
  logic [6:0] evt;
  logic [6:0] clr;
  logic [15:0] status_rd;
  logic [15:0] rdata_q;
  logic [15:0] presc_q;
  logic tick;
  logic homed_q;

  wire [31:0] ge_thr = {ge_hi_q, ge_lo_q};
  wire [31:0] le_thr = {le_hi_q, le_lo_q};
  wire [31:0] init_val = {init_hi_q, init_lo_q};
  wire [2:0] mode = ctrl_q[qesc_pkg::CTRL_MODE_LSB +: 3];
  wire [2:0] index_handling_mode = ctrl_q[qesc_pkg::CTRL_INDEX_HANDLING_MODE_LSB +: 3];
  wire enable = ctrl_q[qesc_pkg::CTRL_EN_BIT];

  // Input edge history
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins;
    end
  end

  wire a_rise = pins.a & ~pins_q.a;
  wire idx_rise = pins.index & ~pins_q.index;
  wire home_rise = pins.home & ~pins_q.home;
  wire a_chg = pins.a ^ pins_q.a;
  wire b_chg = pins.b ^ pins_q.b;
  // One channel changing is a legal step; both at once is dropped as a glitch
  wire quad_step = a_chg ^ b_chg;
  wire quad_up = pins_q.b ^ pins.a;

  // Prescaled tick for timer modes
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_q <= qesc_pkg::RST_HALF;
    end else if (presc_q == 16'(PRESCALE - 1)) begin
      presc_q <= qesc_pkg::RST_HALF;
    end else begin
      presc_q <= presc_q + 16'h0001;
    end
  end
  assign tick = (presc_q == 16'(PRESCALE - 1));

  // Count step and direction per mode
  logic step;
  logic up;
  always_comb begin
    step = 1'b0;
    up = 1'b1;
    case (mode)
      qesc_pkg::MODE_QUAD_X4: begin
        step = quad_step;
        up = quad_up;
      end
      qesc_pkg::MODE_EXT_UPDN: begin
        step = a_rise;
        up = pins.dir;
      end
      qesc_pkg::MODE_GATED_CNT: begin
        step = a_rise & pins.gate;
        up = pins.dir;
      end
      qesc_pkg::MODE_GATED_TMR: begin
        step = tick & pins.gate;
      end
      qesc_pkg::MODE_INT_TMR: begin
        step = tick;
      end
      default: begin
        step = 1'b0;
      end
    endcase
    step = step & enable;
  end

  // Homing: reinitialize once on the first index or home edge after arming
  wire home_mode = (index_handling_mode == qesc_pkg::INDEX_HANDLING_MODE_HOME_IDX) ||
                   (index_handling_mode == qesc_pkg::INDEX_HANDLING_MODE_HOME_SIG);
  wire reinit = enable && !homed_q &&
                (((index_handling_mode == qesc_pkg::INDEX_HANDLING_MODE_HOME_IDX) && idx_rise) ||
                 ((index_handling_mode == qesc_pkg::INDEX_HANDLING_MODE_HOME_SIG) && home_rise));

  wire ctrl_wr = bus.wr && (bus.addr == qesc_pkg::ADDR_CTRL);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      homed_q <= 1'b0;
    end else if (ctrl_wr) begin
      homed_q <= 1'b0;
    end else if (reinit) begin
      homed_q <= 1'b1;
    end
  end

  // Position counter
  wire pos_wrap = step && (up ? (pos_q == qesc_pkg::POS_MAX) : (pos_q == qesc_pkg::RST_WORD));
  always_comb begin
    pos_d = pos_q;
    if (reinit) begin
      pos_d = init_val;
    end else if (step) begin
      pos_d = up ? pos_q + 32'h0000_0001 : pos_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pos_q <= qesc_pkg::RST_WORD;
    end else begin
      pos_q <= pos_d;
    end
  end

  // Index pulse counter follows count direction
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_cnt_q <= qesc_pkg::RST_WORD;
    end else if (enable && idx_rise) begin
      idx_cnt_q <= up ? idx_cnt_q + 32'h0000_0001 : idx_cnt_q - 32'h0000_0001;
    end
  end

  // Interval timer: ticks between count steps, last interval held for reading
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      intv_q <= qesc_pkg::RST_WORD;
      intv_hold_q <= qesc_pkg::RST_WORD;
    end else if (enable && step) begin
      intv_hold_q <= intv_q;
      intv_q <= qesc_pkg::RST_WORD;
    end else if (enable && tick && intv_q != qesc_pkg::POS_MAX) begin
      intv_q <= intv_q + 32'h0000_0001;
    end
  end

  // Signed velocity accumulator, cleared by reading it
  wire vel_rd = bus.rd && (bus.addr == qesc_pkg::ADDR_VEL);
  wire vel_ov = step && (up ? (vel_q == qesc_pkg::VEL_MAX) : (vel_q == qesc_pkg::VEL_MIN));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vel_q <= qesc_pkg::RST_HALF;
    end else if (vel_rd) begin
      vel_q <= step ? (up ? 16'h0001 : 16'hffff) : qesc_pkg::RST_HALF;
    end else if (step) begin
      vel_q <= up ? vel_q + 16'h0001 : vel_q - 16'h0001;
    end
  end

  // Event sources
  always_comb begin
    evt = '0;
    evt[qesc_pkg::EVT_INDEX] = enable & idx_rise;
    evt[qesc_pkg::EVT_HOME] = enable & home_rise;
    evt[qesc_pkg::EVT_VEL_OV] = vel_ov;
    evt[qesc_pkg::EVT_HOMING] = reinit & home_mode;
    evt[qesc_pkg::EVT_POS_OV] = pos_wrap;
    evt[qesc_pkg::EVT_LE] = (pos_q <= le_thr);
    evt[qesc_pkg::EVT_GE] = (pos_q >= ge_thr);
  end

  // Clears: zero written to a flag of status, or one written to the clear register
  wire st_wr = bus.wr && (bus.addr == qesc_pkg::ADDR_STATUS);
  wire clr_wr = bus.wr && (bus.addr == qesc_pkg::ADDR_CLEAR);
  wire en_wr = bus.wr && (bus.addr == qesc_pkg::ADDR_ENABLE);

  genvar gi;
  generate
    for (gi = 0; gi < qesc_pkg::NUM_EVT; gi++) begin : g_evt
      assign clr[gi] = (st_wr && !bus.wdata[2*gi+1]) || (clr_wr && bus.wdata[2*gi+1]);
      // A set in the same cycle as a clear wins so no event is lost
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          flag_q[gi] <= 1'b0;
        end else if (evt[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (clr[gi]) begin
          flag_q[gi] <= 1'b0;
        end
      end
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          en_q[gi] <= 1'b0;
        end else if (st_wr) begin
          en_q[gi] <= bus.wdata[2*gi];
        end else if (en_wr) begin
          // Enable register packs the seven enables into its low bits
          en_q[gi] <= bus.wdata[gi];
        end
      end
      assign status_rd[2*gi+1] = flag_q[gi];
      assign status_rd[2*gi] = en_q[gi];
    end
  endgenerate
  assign status_rd[15:14] = 2'h0;

  assign irq_o = |(flag_q & en_q);

  // Plain read/write registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ge_hi_q <= qesc_pkg::RST_HALF;
      ge_lo_q <= qesc_pkg::RST_HALF;
    end else if (bus.wr) begin
      if (bus.addr == qesc_pkg::ADDR_GE_HI) begin
        ge_hi_q <= bus.wdata;
      end
      if (bus.addr == qesc_pkg::ADDR_GE_LO) begin
        ge_lo_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      le_hi_q <= qesc_pkg::RST_HALF;
      le_lo_q <= qesc_pkg::RST_HALF;
      init_hi_q <= qesc_pkg::RST_HALF;
      init_lo_q <= qesc_pkg::RST_HALF;
    end else if (bus.wr) begin
      if (bus.addr == qesc_pkg::ADDR_LE_HI) begin
        le_hi_q <= bus.wdata;
      end
      if (bus.addr == qesc_pkg::ADDR_LE_LO) begin
        le_lo_q <= bus.wdata;
      end
      if (bus.addr == qesc_pkg::ADDR_INIT_HI) begin
        init_hi_q <= bus.wdata;
      end
      if (bus.addr == qesc_pkg::ADDR_INIT_LO) begin
        init_lo_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= qesc_pkg::RST_HALF;
    end else if (ctrl_wr) begin
      ctrl_q <= bus.wdata;
    end
  end

  // Read mux, data registered for the following cycle; unmapped reads zero
  logic [15:0] rd_mux;
  always_comb begin
    case (bus.addr)
      qesc_pkg::ADDR_STATUS: rd_mux = status_rd;
      qesc_pkg::ADDR_GE_HI: rd_mux = ge_hi_q;
      qesc_pkg::ADDR_GE_LO: rd_mux = ge_lo_q;
      qesc_pkg::ADDR_LE_HI: rd_mux = le_hi_q;
      qesc_pkg::ADDR_LE_LO: rd_mux = le_lo_q;
      qesc_pkg::ADDR_INIT_HI: rd_mux = init_hi_q;
      qesc_pkg::ADDR_INIT_LO: rd_mux = init_lo_q;
      qesc_pkg::ADDR_CTRL: rd_mux = ctrl_q;
      qesc_pkg::ADDR_POS_HI: rd_mux = pos_q[31:16];
      qesc_pkg::ADDR_POS_LO: rd_mux = pos_q[15:0];
      qesc_pkg::ADDR_IDX_HI: rd_mux = idx_cnt_q[31:16];
      qesc_pkg::ADDR_IDX_LO: rd_mux = idx_cnt_q[15:0];
      qesc_pkg::ADDR_INTV_HI: rd_mux = intv_hold_q[31:16];
      qesc_pkg::ADDR_INTV_LO: rd_mux = intv_hold_q[15:0];
      qesc_pkg::ADDR_VEL: rd_mux = vel_q;
      qesc_pkg::ADDR_ENABLE: rd_mux = {9'h000, en_q};
      default: rd_mux = qesc_pkg::RST_HALF;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= qesc_pkg::RST_HALF;
    end else if (bus.rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= qesc_pkg::RST_HALF;
    end
  end
  assign rdata_o = rdata_q;
endmodule : qesc_top
